// ===== cfs_core.sv
// status-flag datapath: adc/sbc (binary or decimal), multiply, divide, flag ops,
// delayed interrupt request visibility, behind an axi4-lite slave
// assumes one 50 MHz clock standing for the oscillator input, async active-low reset
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "cfs_consts.svh"
module cfs_core (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] irq_src_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [4:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [4:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic [7:0] psw_out,
    output logic busy_out,
    output logic core_tick_out,
    output logic irq_take_out
);
    cfs_pkg::cfs_regs_t r_ff;
    cfs_pkg::cfs_regs_t nxt_r;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] dec_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        lo = (lo > 5'h09) ? lo + 5'h06 : lo;
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        hi = (hi > 5'h09) ? hi + 5'h06 : hi;
        return {hi[4], hi[3:0], lo[3:0]};
    endfunction

    // borrow is the inverted carry, as for the binary form
    function automatic logic [8:0] dec_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
        lo = lo[4] ? lo - 5'h06 : lo;
        hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
        hi = hi[4] ? hi - 5'h06 : hi;
        return {~hi[4], hi[3:0], lo[3:0]};
    endfunction

    function automatic logic [3:0] op_cycles(input logic [2:0] op);
        if (op == `CFS_OP_ADC) begin
            return `CFS_CYC_ADC;
        end else if (op == `CFS_OP_SBC) begin
            return `CFS_CYC_SBC;
        end else if (op == `CFS_OP_MUL) begin
            return `CFS_CYC_MUL;
        end else if (op == `CFS_OP_DIV) begin
            return `CFS_CYC_DIV;
        end else if (op == `CFS_OP_NOP) begin
            return `CFS_CYC_OTHER;
        end else begin
            return `CFS_CYC_FLAG;
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] o;
        o = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                o[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic tick;
    logic done;
    logic [8:0] sum;
    logic [15:0] prod;
    assign tick = r_ff.phase;
    assign done = (r_ff.st == cfs_pkg::CFS_ST_EXEC) && tick && (r_ff.cnt == 4'h1);
    assign prod = {8'h00, r_ff.opa} * {8'h00, r_ff.opb};

    always_comb begin
        logic [31:0] wv;
        logic [31:0] rv;
        logic carry;
        wv = 32'h0000_0000;
        rv = 32'h0000_0000;
        carry = r_ff.psw[`CFS_PSW_C];
        sum = 9'h000;
        nxt_r = r_ff;
        nxt_r.phase = ~r_ff.phase;
        nxt_r.src_s1 = irq_src_in;
        nxt_r.src_s2 = r_ff.src_s1;
        // execution
        if (r_ff.st == cfs_pkg::CFS_ST_EXEC && tick) begin
            nxt_r.cnt = r_ff.cnt - 4'h1;
        end
        if (done) begin
            nxt_r.st = cfs_pkg::CFS_ST_IDLE;
            case (r_ff.op)
                `CFS_OP_ADC, `CFS_OP_SBC: begin
                    if (r_ff.psw[`CFS_PSW_D]) begin
                        sum = (r_ff.op == `CFS_OP_ADC) ? dec_add(r_ff.opa, r_ff.opb, carry)
                                                       : dec_sub(r_ff.opa, r_ff.opb, carry);
                        // N, V, Z held: their decimal values carry no meaning
                        nxt_r.psw[`CFS_PSW_C] = sum[8];
                    end else begin
                        sum = (r_ff.op == `CFS_OP_ADC)
                            ? {1'b0, r_ff.opa} + {1'b0, r_ff.opb} + {8'h00, carry}
                            : {1'b0, r_ff.opa} + {1'b0, ~r_ff.opb} + {8'h00, carry};
                        nxt_r.psw[`CFS_PSW_C] = sum[8];
                        nxt_r.psw[`CFS_PSW_Z] = (sum[7:0] == 8'h00);
                        nxt_r.psw[`CFS_PSW_N] = sum[7];
                        nxt_r.psw[`CFS_PSW_V] = (r_ff.opa[7] == (sum[7] ^ 1'b1))
                            && ((r_ff.op == `CFS_OP_ADC) ? r_ff.opb[7] : ~r_ff.opb[7])
                               == r_ff.opa[7];
                    end
                    nxt_r.res = {8'h00, sum[7:0]};
                end
                // status word untouched, flags D and T never read here
                `CFS_OP_MUL: nxt_r.res = prod;
                `CFS_OP_DIV: nxt_r.res = (r_ff.opb == 8'h00) ? {r_ff.opa, `CFS_DIV0_QUOT}
                    : {r_ff.opa % r_ff.opb, r_ff.opa / r_ff.opb};
                `CFS_OP_SEC: nxt_r.psw[`CFS_PSW_C] = 1'b1;
                `CFS_OP_CLC: nxt_r.psw[`CFS_PSW_C] = 1'b0;
                `CFS_OP_CLD: nxt_r.psw[`CFS_PSW_D] = 1'b0;
                default: nxt_r.res = r_ff.res;
            endcase
            // a staged request write lands once a further instruction has ended
            if (r_ff.stage_pend) begin
                nxt_r.irq_vis = r_ff.irq_stage;
                nxt_r.stage_pend = 1'b0;
            end
        end
        // write channel
        if (s_axi_awvalid_in && !r_ff.aw_got) begin
            nxt_r.aw_got = 1'b1;
            nxt_r.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !r_ff.w_got) begin
            nxt_r.w_got = 1'b1;
            nxt_r.w_data = s_axi_wdata_in;
            nxt_r.w_strb = s_axi_wstrb_in;
        end
        if (r_ff.bvalid && s_axi_bready_in) begin
            nxt_r.bvalid = 1'b0;
        end
        if (r_ff.aw_got && r_ff.w_got && !r_ff.bvalid) begin
            nxt_r.aw_got = 1'b0;
            nxt_r.w_got = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = `CFS_RESP_OKAY;
            if (r_ff.aw_addr == `CFS_OFS_PSW) begin
                wv = merge({24'h0, nxt_r.psw}, r_ff.w_data, r_ff.w_strb);
                nxt_r.psw = wv[7:0];
            end else if (r_ff.aw_addr == `CFS_OFS_OPER) begin
                // ignored while an instruction runs; operands stay stable
                if (r_ff.st == cfs_pkg::CFS_ST_IDLE) begin
                    wv = merge({13'h0, r_ff.op, r_ff.opb, r_ff.opa}, r_ff.w_data, r_ff.w_strb);
                    nxt_r.opa = wv[`CFS_OPER_A +: 8];
                    nxt_r.opb = wv[`CFS_OPER_B +: 8];
                    nxt_r.op = wv[`CFS_OPER_OP +: 3];
                    nxt_r.cnt = op_cycles(wv[`CFS_OPER_OP +: 3]);
                    nxt_r.st = cfs_pkg::CFS_ST_EXEC;
                end
            end else if (r_ff.aw_addr == `CFS_OFS_IRQ) begin
                wv = merge({24'h0, r_ff.irq_stage}, r_ff.w_data, r_ff.w_strb);
                nxt_r.irq_stage = wv[7:0];
                nxt_r.stage_pend = 1'b1;
            end else if (r_ff.aw_addr == `CFS_OFS_RES || r_ff.aw_addr == `CFS_OFS_STAT) begin
                nxt_r.bresp = `CFS_RESP_OKAY;
            end else begin
                nxt_r.bresp = `CFS_RESP_SLVERR;
            end
        end
        // sources set after any software update, so a set wins over a clear
        nxt_r.irq_vis = nxt_r.irq_vis | r_ff.src_s2;
        // read channel
        if (r_ff.rvalid && s_axi_rready_in) begin
            nxt_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && !r_ff.rvalid) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp = `CFS_RESP_OKAY;
            if (s_axi_araddr_in == `CFS_OFS_PSW) begin
                rv = {24'h0, r_ff.psw};
            end else if (s_axi_araddr_in == `CFS_OFS_OPER) begin
                rv = {13'h0, r_ff.op, r_ff.opb, r_ff.opa};
            end else if (s_axi_araddr_in == `CFS_OFS_RES) begin
                rv = {16'h0, r_ff.res};
            end else if (s_axi_araddr_in == `CFS_OFS_IRQ) begin
                rv = {24'h0, r_ff.irq_vis};
            end else if (s_axi_araddr_in == `CFS_OFS_STAT) begin
                rv = {26'h0, r_ff.cnt, r_ff.stage_pend, r_ff.st == cfs_pkg::CFS_ST_EXEC};
            end else begin
                nxt_r.rresp = `CFS_RESP_SLVERR;
            end
            nxt_r.rdata = rv;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r_ff <= '0;
            r_ff.st <= cfs_pkg::CFS_ST_IDLE;
            r_ff.psw <= `CFS_PSW_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready_out = !r_ff.aw_got;
    assign s_axi_wready_out = !r_ff.w_got;
    assign s_axi_bvalid_out = r_ff.bvalid;
    assign s_axi_bresp_out = r_ff.bresp;
    assign s_axi_arready_out = !r_ff.rvalid;
    assign s_axi_rvalid_out = r_ff.rvalid;
    assign s_axi_rdata_out = r_ff.rdata;
    assign s_axi_rresp_out = r_ff.rresp;
    assign psw_out = r_ff.psw;
    assign busy_out = (r_ff.st == cfs_pkg::CFS_ST_EXEC);
    assign core_tick_out = tick;
    // maskable requests held off while interrupt disable is set
    assign irq_take_out = (|r_ff.irq_vis) && !r_ff.psw[`CFS_PSW_I];

    ////////////////////////////////////////////////////////////////////////////////
    logic live_ff;
    logic [4:0] ec_ff;
    logic wr_irq;
    assign wr_irq = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid && r_ff.aw_addr == `CFS_OFS_IRQ;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            live_ff <= 1'b0;
            ec_ff <= 5'h00;
        end else begin
            live_ff <= 1'b1;
            ec_ff <= busy_out ? ec_ff + 5'h01 : 5'h00;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    reset_idis_a: assert property (!live_ff |-> psw_out[`CFS_PSW_I])
        else $error("interrupt disable not set after reset");
    tick_half_a: assert property (core_tick_out |=> !core_tick_out ##1 core_tick_out)
        else $error("core tick not half rate");
    dec_digits_a: assert property (done && r_ff.psw[`CFS_PSW_D] && r_ff.op == `CFS_OP_ADC
        && r_ff.opa[3:0] < 4'ha && r_ff.opa[7:4] < 4'ha && r_ff.opb[3:0] < 4'ha
        && r_ff.opb[7:4] < 4'ha |=> r_ff.res[3:0] < 4'ha && r_ff.res[7:4] < 4'ha)
        else $error("decimal add gave a non-decimal digit");
    dec_nvz_a: assert property (done && r_ff.psw[`CFS_PSW_D] && !wr_irq
        && (r_ff.op == `CFS_OP_ADC || r_ff.op == `CFS_OP_SBC) && !r_ff.aw_got
        |=> psw_out[7:6] == $past(psw_out[7:6]) && psw_out[1] == $past(psw_out[1]))
        else $error("decimal op disturbed N V Z");
    mul_value_a: assert property (done && r_ff.op == `CFS_OP_MUL
        |=> r_ff.res == $past(prod))
        else $error("product wrong");
    muldiv_psw_a: assert property (done && (r_ff.op == `CFS_OP_MUL || r_ff.op == `CFS_OP_DIV)
        && !r_ff.aw_got |=> $stable(psw_out))
        else $error("multiply or divide changed the status word");
    irq_delay_a: assert property (wr_irq && !done |=> r_ff.stage_pend
        && r_ff.irq_vis == ($past(r_ff.irq_vis) | $past(r_ff.src_s2)))
        else $error("request write visible too early");
    exec_len_a: assert property (done |-> ec_ff + 5'h02 >= {op_cycles(r_ff.op), 1'b0}
        && ec_ff + 5'h01 <= {op_cycles(r_ff.op), 1'b0})
        else $error("instruction length not cycles times two");
    irq_gate_a: assert property (psw_out[`CFS_PSW_I] |-> !irq_take_out)
        else $error("request taken while disabled");

    dec_add_c: cover property (done && r_ff.psw[`CFS_PSW_D] && r_ff.op == `CFS_OP_ADC);
    dec_sub_c: cover property (done && r_ff.psw[`CFS_PSW_D] && r_ff.op == `CFS_OP_SBC);
    div_done_c: cover property (done && r_ff.op == `CFS_OP_DIV);
    irq_take_c: cover property (irq_take_out);
endmodule

// ===== cfs_consts.svh
// constants for the status-flag datapath: offsets, field positions, resets, op codes
// assumes inclusion by cfs_core.sv and the bench only; cfs_pkg.sv does not include it
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH
// register byte offsets
`define CFS_OFS_PSW 5'h00
`define CFS_OFS_OPER 5'h04
`define CFS_OFS_RES 5'h08
`define CFS_OFS_IRQ 5'h0c
`define CFS_OFS_STAT 5'h10
// status word bit positions
`define CFS_PSW_C 0
`define CFS_PSW_Z 1
`define CFS_PSW_I 2
`define CFS_PSW_D 3
`define CFS_PSW_T 5
`define CFS_PSW_V 6
`define CFS_PSW_N 7
`define CFS_PSW_RST 8'h04
// operand register field positions
`define CFS_OPER_A 0
`define CFS_OPER_B 8
`define CFS_OPER_OP 16
// op codes
`define CFS_OP_ADC 3'h0
`define CFS_OP_SBC 3'h1
`define CFS_OP_MUL 3'h2
`define CFS_OP_DIV 3'h3
`define CFS_OP_SEC 3'h4
`define CFS_OP_CLC 3'h5
`define CFS_OP_CLD 3'h6
`define CFS_OP_NOP 3'h7
// quotient reported for a zero divisor; remainder slot keeps the dividend
`define CFS_DIV0_QUOT 8'hff
// core cycles per instruction
`define CFS_CYC_ADC 4'h3
`define CFS_CYC_SBC 4'h3
`define CFS_CYC_MUL 4'hf
`define CFS_CYC_DIV 4'hf
`define CFS_CYC_FLAG 4'h2
`define CFS_CYC_OTHER 4'h1
// axi responses
`define CFS_RESP_OKAY 2'h0
`define CFS_RESP_SLVERR 2'h2
`endif

// ===== cfs_pkg.sv
// types for the status-flag datapath
// assumes no other file; nothing here comes from cfs_consts.svh
package cfs_pkg;
    typedef enum logic [1:0] {
        CFS_ST_IDLE = 2'b01,
        CFS_ST_EXEC = 2'b10
    } cfs_state_t;

    typedef struct packed {
        cfs_state_t st;
        logic phase;
        logic [3:0] cnt;
        logic [7:0] psw;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [2:0] op;
        logic [15:0] res;
        logic [7:0] irq_vis;
        logic [7:0] irq_stage;
        logic stage_pend;
        logic [7:0] src_s1;
        logic [7:0] src_s2;
        logic aw_got;
        logic w_got;
        logic [4:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cfs_regs_t;
endpackage

// ===== cfs_tb.sv
// self-checking bench for the status-flag datapath behind its axi4-lite slave
// assumes cfs_core and cfs_consts.svh in the same folder, one 50 MHz clock
`timescale 1ns/1ps
`include "cfs_consts.svh"
module testbench;
logic clk_in, arst_n_in;
logic [7:0] irq_src_in, psw;
logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
logic [4:0] awaddr, araddr;
logic [31:0] wdata, rdata, d;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, r;
logic busy, tick, take;
int n_errors, tests_run, cyc, run, busy_len;

cfs_core dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .irq_src_in(irq_src_in),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .psw_out(psw), .busy_out(busy),
    .core_tick_out(tick), .irq_take_out(take));

initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
end

// length of the last finished busy run, sampled mid-cycle to stay clear of the edge
always @(negedge clk_in) begin
    if (busy === 1'b1) begin
        run++;
    end else begin
        if (run != 0) busy_len = run;
        run = 0;
    end
end

// hang guard: the whole sequence needs a few hundred cycles
always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
        n_errors++;
        finish_test();
    end
end

////////////////////////////////////////////////////////////////////////////////
task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask

task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
        n_errors++;
        $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
endtask

// ready is sampled at the falling edge, so the rising edge that moves the item is known
task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic ta, tw;
    bit done;
    done = 0;
    @(posedge clk_in);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!done) begin
        @(negedge clk_in);
        ta = awvalid && awready;
        tw = wvalid && wready;
        if (bvalid === 1'b1 && bready) begin
            resp = bresp;
            done = 1;
        end
        @(posedge clk_in);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        if (done) bready <= 1'b0;
    end
endtask

task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ta;
    bit done;
    done = 0;
    @(posedge clk_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done) begin
        @(negedge clk_in);
        ta = arvalid && arready;
        if (rvalid === 1'b1 && rready) begin
            v = rdata;
            resp = rresp;
            done = 1;
        end
        @(posedge clk_in);
        if (ta) arvalid <= 1'b0;
        if (done) rready <= 1'b0;
    end
endtask

task automatic wro(input logic [4:0] a, input logic [31:0] v);
    wr(a, v, r);
    check(r, `CFS_RESP_OKAY, "write response");
endtask

task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string msg);
    rd(a, d, r);
    check(r, `CFS_RESP_OKAY, "read response");
    check(d, exp, msg);
endtask

task automatic op(input logic [2:0] code, input logic [7:0] a, input logic [7:0] b);
    wro(`CFS_OFS_OPER, {13'h0, code, b, a});
    repeat (200) begin
        @(negedge clk_in);
        if (busy === 1'b0) break;
    end
    check(busy, 32'h0, "instruction finished");
endtask

////////////////////////////////////////////////////////////////////////////////
task automatic t_reset();
    check(psw, 32'h04, "status after reset");
    check(busy, 32'h0, "busy after reset");
    rdc(`CFS_OFS_PSW, 32'h04, "status read after reset");
    $display("test reset done");
endtask

task automatic t_flags();
    op(`CFS_OP_SEC, 8'h00, 8'h00);
    check(psw, 32'h05, "carry set op");
    op(`CFS_OP_CLC, 8'h00, 8'h00);
    check(psw, 32'h04, "carry clear op");
    wro(`CFS_OFS_PSW, 32'h0c);
    op(`CFS_OP_CLD, 8'h00, 8'h00);
    check(psw, 32'h04, "decimal clear op");
    $display("test flag ops done");
endtask

task automatic t_binary();
    wro(`CFS_OFS_PSW, 32'h05);
    op(`CFS_OP_ADC, 8'h7f, 8'h00);
    rd(`CFS_OFS_RES, d, r);
    check(d[7:0], 8'h80, "binary add with carry");
    check(psw[0], 1'b0, "binary add carry out");
    check(psw, 32'hc4, "binary add negative and overflow");
    check(32'(busy_len inside {5, 6}), 32'h1, "add length in clocks");
    $display("test binary done");
endtask

// only the carry is judged: the other arithmetic flags carry no meaning here
task automatic dec(input logic c, input logic [2:0] code, input logic [7:0] a,
    input logic [7:0] b, input logic [7:0] res, input logic cout);
    wro(`CFS_OFS_PSW, {28'h0, 4'hc} | 32'(c));
    op(code, a, b);
    rd(`CFS_OFS_RES, d, r);
    check(d[7:0], res, "decimal result");
    check(psw[0], cout, "decimal carry");
endtask

task automatic t_decimal();
    dec(1'b0, `CFS_OP_ADC, 8'h45, 8'h38, 8'h83, 1'b0);
    dec(1'b0, `CFS_OP_ADC, 8'h99, 8'h01, 8'h00, 1'b1);
    dec(1'b1, `CFS_OP_SBC, 8'h50, 8'h25, 8'h25, 1'b1);
    dec(1'b1, `CFS_OP_SBC, 8'h10, 8'h20, 8'h90, 1'b0);
    $display("test decimal done");
endtask

task automatic t_muldiv();
    wro(`CFS_OFS_PSW, 32'h2d);
    op(`CFS_OP_MUL, 8'h12, 8'h34);
    rdc(`CFS_OFS_RES, 32'h03a8, "product with index and decimal set");
    check(psw, 32'h2d, "status kept by product");
    check(32'(busy_len inside {29, 30}), 32'h1, "product length in clocks");
    op(`CFS_OP_DIV, 8'h64, 8'h07);
    rdc(`CFS_OFS_RES, 32'h020e, "quotient with index and decimal set");
    check(psw, 32'h2d, "status kept by divide");
    wro(`CFS_OFS_PSW, 32'h04);
    op(`CFS_OP_MUL, 8'h12, 8'h34);
    rdc(`CFS_OFS_RES, 32'h03a8, "product in binary mode");
    op(`CFS_OP_DIV, 8'h33, 8'h00);
    rdc(`CFS_OFS_RES, 32'h33ff, "divide by zero");
    check(psw, 32'h04, "status kept by divide by zero");
    $display("test multiply divide done");
endtask

task automatic t_irq();
    wro(`CFS_OFS_IRQ, 32'h01);
    rdc(`CFS_OFS_IRQ, 32'h00, "request write not yet seen");
    rdc(`CFS_OFS_STAT, 32'h02, "request write pending");
    op(`CFS_OP_CLC, 8'h00, 8'h00);
    rdc(`CFS_OFS_IRQ, 32'h01, "request seen after one instruction");
    check(take, 32'h0, "request held off by disable flag");
    wro(`CFS_OFS_PSW, 32'h00);
    @(negedge clk_in);
    check(take, 32'h1, "request taken once enabled");
    wro(`CFS_OFS_PSW, 32'h04);
    @(negedge clk_in);
    check(take, 32'h0, "request masked again");
    @(posedge clk_in);
    irq_src_in <= 8'h80;
    repeat (4) @(posedge clk_in);
    irq_src_in <= 8'h00;
    rdc(`CFS_OFS_IRQ, 32'h81, "source request kept");
    $display("test interrupt request done");
endtask

task automatic t_bus();
    logic p;
    rd(5'h14, d, r);
    check(r, `CFS_RESP_SLVERR, "unmapped read response");
    check(d, 32'h0, "unmapped read data");
    wr(5'h18, 32'hffffffff, r);
    check(r, `CFS_RESP_SLVERR, "unmapped write response");
    wro(`CFS_OFS_RES, 32'hffffffff);
    rdc(`CFS_OFS_RES, 32'h33ff, "result is read only");
    @(negedge clk_in);
    p = tick;
    repeat (8) begin
        @(negedge clk_in);
        check(tick, {31'h0, ~p}, "core clock at half rate");
        p = tick;
    end
    $display("test bus and core clock done");
endtask

// reset in mid-run, after software has cleared interrupt disable
task automatic t_rereset();
    wro(`CFS_OFS_PSW, 32'h00);
    check(psw, 32'h00, "status cleared before reset");
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(psw, 32'h04, "status during second reset");
    check(busy, 32'h0, "busy during second reset");
    arst_n_in <= 1'b1;
    rdc(`CFS_OFS_PSW, 32'h04, "status read after second reset");
    check(take, 32'h0, "no request taken after second reset");
    $display("test second reset done");
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
    arst_n_in = 1'b0;
    irq_src_in = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_flags();
    t_binary();
    t_decimal();
    t_muldiv();
    t_irq();
    t_bus();
    t_rereset();
    finish_test();
end
endmodule
